/* File: arbs_pkg.sv */
// package: opcodes, widths and reset values for the rotate and set-bit datapath
package arbs_pkg;
    localparam int ACC_W = 8;
    localparam logic [7:0] OPC_ROTATE_LEFT_VIA_CARRY = 8'h33;
    localparam logic [7:0] OPC_ROTATE_RIGHT_PLAIN = 8'h03;
    localparam logic [7:0] OPC_ROTATE_RIGHT_VIA_CARRY = 8'h13;
    localparam logic [7:0] OPC_SET_BIT_OP_CARRY = 8'hd3;
    localparam logic [7:0] OPC_SET_BIT_OP_DIRECT = 8'hd2;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic CARRY_RESET = 1'b0;
    localparam int ACC_MSB = 7;
    localparam int ACC_LSB = 0;
    localparam int BIT_ADDR_W = 8;
    typedef enum logic [1:0] {ARBS_OP_NONE, ARBS_OP_ROT, ARBS_OP_SETC, ARBS_OP_SETBIT} arbs_op_e;
endpackage

/* File: arbs_datapath.sv */
// execution datapath for accumulator rotates and the set-bit operation
// Function
// - left rotate via carry: acc shifts left, bit 7 to carry, carry to bit 0.
// - plain right rotate: acc rotates right, bit 0 to bit 7, carry kept.
// - right rotate via carry: bit 0 to carry, carry to bit 7.
// - set-bit forces target to one and leaves every other flag alone.
// - set-bit on carry is one byte, one cycle, sets carry.
// - set-bit on direct bit is two bytes, second is bit address, one cycle.
`timescale 1ns/1ps
module arbs_datapath #(
    parameter int ADDR_W = arbs_pkg::BIT_ADDR_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic instr_valid,
    input wire logic [7:0] opcode,
    input wire logic [ADDR_W-1:0] bit_addr,
    output logic [arbs_pkg::ACC_W-1:0] acc,
    output logic carry,
    output logic bit_set_strobe,
    output logic [ADDR_W-1:0] bit_set_addr,
    output logic done
);
    import arbs_pkg::*;

    // ************************************************************
    // decode
    // ************************************************************
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;
    logic carry_reg;
    logic carry_next;
    logic strobe_reg;
    logic strobe_next;
    logic done_reg;
    logic done_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    arbs_op_e op_kind;

    // bit_addr only matters when the two-byte direct form is decoded
    wire is_rol_carry = instr_valid && opcode == OPC_ROTATE_LEFT_VIA_CARRY;
    wire is_ror_plain = instr_valid && opcode == OPC_ROTATE_RIGHT_PLAIN;
    wire is_ror_carry = instr_valid && opcode == OPC_ROTATE_RIGHT_VIA_CARRY;
    wire is_set_carry = instr_valid && opcode == OPC_SET_BIT_OP_CARRY;
    wire is_set_direct = instr_valid && opcode == OPC_SET_BIT_OP_DIRECT;
    wire is_rotate = is_rol_carry || is_ror_plain || is_ror_carry;
    wire known_op = is_rotate || is_set_carry || is_set_direct;

    always_comb begin
        op_kind = ARBS_OP_NONE;
        if (is_rotate) begin
            op_kind = ARBS_OP_ROT;
        end else if (is_set_carry) begin
            op_kind = ARBS_OP_SETC;
        end else if (is_set_direct) begin
            op_kind = ARBS_OP_SETBIT;
        end
    end

    // ************************************************************
    // rotate results
    // ************************************************************
    wire [ACC_W-1:0] rol_carry_val;
    wire [ACC_W-1:0] ror_plain_val;
    wire [ACC_W-1:0] ror_carry_val;

    // each bit takes its neighbour; the two right rotates differ only in bit 7
    genvar gi;
    for (gi = 0; gi < ACC_W; gi++) begin : g_rot_bit
        if (gi == ACC_MSB) begin : g_top
            assign rol_carry_val[gi] = acc_reg[gi-1];
            assign ror_plain_val[gi] = acc_reg[ACC_LSB];
            assign ror_carry_val[gi] = carry_reg;
        end else if (gi == ACC_LSB) begin : g_bottom
            assign rol_carry_val[gi] = carry_reg;
            assign ror_plain_val[gi] = acc_reg[gi+1];
            assign ror_carry_val[gi] = acc_reg[gi+1];
        end else begin : g_middle
            assign rol_carry_val[gi] = acc_reg[gi-1];
            assign ror_plain_val[gi] = acc_reg[gi+1];
            assign ror_carry_val[gi] = acc_reg[gi+1];
        end
    end

    // ************************************************************
    // next values
    // ************************************************************
    always_comb begin
        acc_next = acc_reg;
        carry_next = carry_reg;
        case (op_kind)
            ARBS_OP_ROT: begin
                if (is_rol_carry) begin
                    acc_next = rol_carry_val;
                    carry_next = acc_reg[ACC_MSB];
                end else if (is_ror_plain) begin
                    acc_next = ror_plain_val;
                end else begin
                    acc_next = ror_carry_val;
                    carry_next = acc_reg[ACC_LSB];
                end
            end
            ARBS_OP_SETC: begin
                carry_next = 1'b1;
            end
            ARBS_OP_SETBIT: begin
                // only the outside bit changes, through the strobe below
                acc_next = acc_reg;
                carry_next = carry_reg;
            end
            default: begin
                acc_next = acc_reg;
                carry_next = carry_reg;
            end
        endcase
    end

    // the direct bit lives in an outside bit memory, so it is handed out as a strobe
    assign strobe_next = is_set_direct;
    assign addr_next = is_set_direct ? bit_addr : addr_reg;
    // done is a hand-back for the sequencer; idle or unknown cycles leave it low
    assign done_next = known_op;

    // ************************************************************
    // state
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            acc_reg <= ACC_RESET;
        end else begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            carry_reg <= CARRY_RESET;
        end else begin
            carry_reg <= carry_next;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= strobe_next;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            addr_reg <= '0;
        end else begin
            addr_reg <= addr_next;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    assign acc = acc_reg;
    assign carry = carry_reg;
    assign bit_set_strobe = strobe_reg;
    assign bit_set_addr = addr_reg;
    assign done = done_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_rol_carry;
        is_rol_carry;
    endsequence

    sequence s_ror_plain;
        is_ror_plain;
    endsequence

    sequence s_ror_carry;
        is_ror_carry;
    endsequence

    sequence s_set_carry;
        is_set_carry;
    endsequence

    sequence s_set_direct;
        is_set_direct;
    endsequence

    sequence s_strobe_raised;
        bit_set_strobe && bit_set_addr == $past(bit_addr);
    endsequence

    sequence s_strobe_dropped;
        !bit_set_strobe || $past(is_set_direct);
    endsequence

    a_rol_carry_res: assert property (@(posedge mclk) disable iff (!resetn)
        s_rol_carry |=> acc == {$past(acc[ACC_MSB-1:ACC_LSB]), $past(carry)}
            && carry == $past(acc[ACC_MSB]))
        else $error("left rotate via carry wrong");

    a_ror_plain_res: assert property (@(posedge mclk) disable iff (!resetn)
        s_ror_plain |=> acc == {$past(acc[ACC_LSB]), $past(acc[ACC_MSB:ACC_LSB+1])}
            && $stable(carry))
        else $error("plain right rotate wrong");

    a_ror_carry_res: assert property (@(posedge mclk) disable iff (!resetn)
        s_ror_carry |=> acc == {$past(carry), $past(acc[ACC_MSB:ACC_LSB+1])}
            && carry == $past(acc[ACC_LSB]))
        else $error("right rotate via carry wrong");

    a_setc_flag: assert property (@(posedge mclk) disable iff (!resetn)
        s_set_carry |=> carry && $stable(acc))
        else $error("carry not set");

    a_setbit_keep: assert property (@(posedge mclk) disable iff (!resetn)
        s_set_direct |=> $stable(acc) && $stable(carry))
        else $error("direct set changed flags");

    a_setbit_strobe: assert property (@(posedge mclk) disable iff (!resetn)
        s_set_direct |=> s_strobe_raised ##1 s_strobe_dropped)
        else $error("direct set strobe wrong");

    a_strobe_only_direct: assert property (@(posedge mclk) disable iff (!resetn)
        !is_set_direct |=> !bit_set_strobe)
        else $error("strobe without direct set");

    a_addr_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !is_set_direct |=> $stable(bit_set_addr))
        else $error("bit address moved without direct set");

    a_back_to_back: assert property (@(posedge mclk) disable iff (!resetn)
        s_rol_carry ##1 s_rol_carry |=>
            acc == {$past(acc[ACC_MSB-2:ACC_LSB], 2), $past(carry, 2), $past(acc[ACC_MSB], 2)}
            && carry == $past(acc[ACC_MSB-1], 2))
        else $error("second rotate did not see the first result");

    a_idle_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !known_op |=> $stable(acc) && $stable(carry) && !done)
        else $error("state moved without instruction");

    a_done_pulse: assert property (@(posedge mclk) disable iff (!resetn)
        known_op |=> done)
        else $error("done missing");
endmodule

/* File: tb_accumulator_rotate_bit_set.sv */
// testbench: rotate and set-bit datapath driven through its instruction port
`timescale 1ns/1ps
module tb_accumulator_rotate_bit_set;
    import arbs_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic instr_valid = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [7:0] bit_addr = 8'h00;
    logic [7:0] acc, bit_set_addr;
    logic carry, bit_set_strobe, done;
    logic [7:0] a_m = ACC_RESET;
    logic [7:0] ad_m = 8'h00;
    logic c_m = CARRY_RESET;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    arbs_datapath i_dut (.mclk(mclk), .resetn(resetn), .instr_valid(instr_valid),
        .opcode(opcode), .bit_addr(bit_addr), .acc(acc), .carry(carry),
        .bit_set_strobe(bit_set_strobe), .bit_set_addr(bit_set_addr), .done(done));
    initial forever #4 mclk = ~mclk;
    // ***********************************
    // checking helpers
    // ***********************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // the run needs well under a hundred cycles; a hang stops here
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_bit(string n, logic e, logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    // one instruction; the model moves only on a recognised opcode
    task automatic step(logic v, logic [7:0] op, logic [7:0] ad);
        logic k;
        k = v && (op inside {OPC_ROTATE_LEFT_VIA_CARRY, OPC_ROTATE_RIGHT_PLAIN,
            OPC_ROTATE_RIGHT_VIA_CARRY, OPC_SET_BIT_OP_CARRY, OPC_SET_BIT_OP_DIRECT});
        instr_valid = v;
        opcode = op;
        bit_addr = ad;
        @(posedge mclk);
        #1;
        if (k && op == OPC_ROTATE_LEFT_VIA_CARRY) {c_m, a_m} = {a_m, c_m};
        else if (k && op == OPC_ROTATE_RIGHT_PLAIN) a_m = {a_m[ACC_LSB], a_m[ACC_MSB:1]};
        else if (k && op == OPC_ROTATE_RIGHT_VIA_CARRY) {a_m, c_m} = {c_m, a_m};
        else if (k && op == OPC_SET_BIT_OP_CARRY) c_m = 1'b1;
        else if (k && op == OPC_SET_BIT_OP_DIRECT) ad_m = ad;
        chk("acc", a_m, acc);
        chk_bit("carry", c_m, carry);
        chk_bit("done", k, done);
        chk_bit("strobe", k && op == OPC_SET_BIT_OP_DIRECT, bit_set_strobe);
        chk("addr", ad_m, bit_set_addr);
    endtask
    // ***********************************
    // scenarios
    // ***********************************
    task automatic t_carry_set();
        step(1'b1, OPC_SET_BIT_OP_CARRY, 8'h00);
        step(1'b1, OPC_SET_BIT_OP_CARRY, 8'h00);
    endtask
    task automatic t_rotations();
        step(1'b1, OPC_ROTATE_LEFT_VIA_CARRY, 8'h00);
        step(1'b1, OPC_ROTATE_LEFT_VIA_CARRY, 8'h00);
        step(1'b1, OPC_SET_BIT_OP_CARRY, 8'h00);
        step(1'b1, OPC_ROTATE_LEFT_VIA_CARRY, 8'h00);
        step(1'b1, OPC_ROTATE_RIGHT_VIA_CARRY, 8'h00);
        step(1'b1, OPC_ROTATE_RIGHT_VIA_CARRY, 8'h00);
        step(1'b1, OPC_ROTATE_RIGHT_PLAIN, 8'h00);
        step(1'b1, OPC_SET_BIT_OP_CARRY, 8'h00);
        step(1'b1, OPC_ROTATE_RIGHT_PLAIN, 8'h00);
    endtask
    task automatic t_direct();
        step(1'b1, OPC_SET_BIT_OP_DIRECT, 8'h90);
        step(1'b1, OPC_SET_BIT_OP_DIRECT, 8'h5a);
        step(1'b1, OPC_ROTATE_LEFT_VIA_CARRY, 8'h33);
    endtask
    // reset in mid-run right after a direct set: the strobe must be low after the next clock edge too
    task automatic t_mid_reset();
        step(1'b1, OPC_SET_BIT_OP_DIRECT, 8'ha5);
        instr_valid = 1'b0;
        resetn = 1'b0;
        a_m = ACC_RESET;
        c_m = CARRY_RESET;
        ad_m = 8'h00;
        @(posedge mclk);
        #1;
        chk("acc", a_m, acc);
        chk_bit("carry", c_m, carry);
        chk_bit("done", 1'b0, done);
        chk_bit("strobe", 1'b0, bit_set_strobe);
        chk("addr", ad_m, bit_set_addr);
        resetn = 1'b1;
    endtask
    // shift c5 in from carry, then walk the rotate examples; bit 7 reaches carry here
    task automatic t_examples();
        logic [7:0] pat;
        pat = 8'hc5;
        for (int i = ACC_MSB; i >= ACC_LSB; i--) begin
            if (pat[i]) step(1'b1, OPC_SET_BIT_OP_CARRY, 8'h00);
            step(1'b1, OPC_ROTATE_LEFT_VIA_CARRY, 8'h00);
        end
        chk("acc", 8'hc5, acc);
        step(1'b1, OPC_ROTATE_LEFT_VIA_CARRY, 8'h00);
        chk("acc", 8'h8a, acc);
        chk_bit("carry", 1'b1, carry);
        step(1'b1, OPC_ROTATE_RIGHT_VIA_CARRY, 8'h00);
        step(1'b1, OPC_ROTATE_RIGHT_VIA_CARRY, 8'h00);
        chk("acc", 8'h62, acc);
        chk_bit("carry", 1'b1, carry);
        step(1'b1, OPC_ROTATE_LEFT_VIA_CARRY, 8'h00);
        step(1'b1, OPC_ROTATE_RIGHT_PLAIN, 8'h00);
        chk("acc", 8'he2, acc);
        chk_bit("carry", 1'b0, carry);
    endtask
    task automatic t_ignored();
        step(1'b0, OPC_ROTATE_LEFT_VIA_CARRY, 8'h00);
        step(1'b1, 8'hff, 8'h12);
        step(1'b0, OPC_SET_BIT_OP_DIRECT, 8'h77);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        resetn = 1'b1;
        t_carry_set();
        t_rotations();
        t_direct();
        t_mid_reset();
        t_examples();
        t_ignored();
        print_verdict();
    end
endmodule
